// ==== src/udisc_pkg.sv ====
// Shared constants and types of the USB interrupt and suspend clock block
package udisc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned T_PULSE_NS     = 166;
  localparam int unsigned T_PSEUDO_FRAME_FLAG_NS      = 1000000;
  localparam int unsigned T_SUSP_NS      = 2000000;
  localparam int unsigned T_RESUME_NS    = 500000;
  localparam int unsigned T_SLOW_HALF_NS = 5000;
  localparam int unsigned PULSE_CYC  = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PSEUDO_FRAME_FLAG_CYC   = T_PSEUDO_FRAME_FLAG_NS * CLK_MHZ / 1000;
  localparam int unsigned SUSP_CYC   = T_SUSP_NS * CLK_MHZ / 1000;
  localparam int unsigned RESUME_CYC = T_RESUME_NS * CLK_MHZ / 1000;
  localparam int unsigned SLOW_HALF_CYC = T_SLOW_HALF_NS * CLK_MHZ / 1000;
  localparam logic [1:0]  MISSED_LIMIT  = 2'h3;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_EVENT     = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h04;
  localparam logic [7:0] OFS_MODE      = 8'h08;
  localparam logic [7:0] OFS_HWCFG     = 8'h0C;
  localparam logic [7:0] OFS_EP_STATUS = 8'h40;
  localparam logic [7:0] OFS_EP_CONFIG = 8'h80;

  // Event register fields
  localparam int unsigned EV_BUS_RESET = 0;
  localparam int unsigned EV_RESUME    = 1;
  localparam int unsigned EV_SUSP_CHG  = 2;
  localparam int unsigned EV_EOT       = 3;
  localparam int unsigned EV_SOF       = 4;
  localparam int unsigned EV_PSEUDO_FRAME_FLAG      = 5;
  localparam int unsigned EV_BUS_STATE = 7;
  localparam int unsigned EV_EP_LO     = 8;
  localparam logic [23:0] EV_RD_CLR    = 24'h00001B;
  localparam logic [23:0] EV_W1C       = 24'h000024;
  localparam logic [23:0] EV_LATCHED   = 24'hFFFF3F;

  // Mode and configuration fields
  localparam int unsigned MODE_GLOBAL = 0;
  localparam int unsigned MODE_GO_SUSPEND_BIT = 1;
  localparam int unsigned CFG_POL     = 0;
  localparam int unsigned CFG_PULSE   = 1;
  localparam int unsigned CFG_OSC_RUN = 2;
  localparam int unsigned CFG_SLOW_DIS = 3;
  localparam int unsigned CFG_DIV_LO  = 4;
  localparam int unsigned EPC_ENABLE  = 0;

  // Reset values
  localparam logic [23:0] IRQ_EN_RST = 24'h000000;
  localparam logic [1:0]  MODE_RST   = 2'h0;
  localparam logic [7:0]  HWCFG_RST  = 8'h04;
  localparam logic [7:0]  EPC_RST    = 8'h00;
  localparam logic [7:0]  EPC_CTRL   = 8'h01;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    SP_AWAKE  = 4'h1,
    SP_ENTER  = 4'h2,
    SP_ASLEEP = 4'h4,
    SP_RESUME = 4'h8
  } udisc_susp_t;

  typedef enum logic [1:0] {
    TK_OUT_ACKED = 2'h0,
    TK_IN_ACKED  = 2'h1,
    TK_ISO_PKT   = 2'h2,
    TK_NO_ACK    = 2'h3
  } udisc_tok_t;

  typedef struct packed {
    logic bus_reset;
    logic resume;
    logic sof;
    logic dma_count_zero;
    logic bus_suspended;
  } udisc_usb_ev_t;

  typedef struct packed {
    logic       valid;
    udisc_tok_t kind;
    logic [3:0] ep;
  } udisc_txn_t;

endpackage

// ==== src/udisc_core.sv ====
// USB device interrupt logic with suspend and clock output sequencing
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module udisc_core #(
  parameter int unsigned PSEUDO_FRAME_FLAG_CYC   = udisc_pkg::PSEUDO_FRAME_FLAG_CYC,
  parameter int unsigned SUSP_CYC   = udisc_pkg::SUSP_CYC,
  parameter int unsigned RESUME_CYC = udisc_pkg::RESUME_CYC
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  // Avalon-MM slave
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // Events from the serial engine and DMA
  input  wire udisc_pkg::udisc_usb_ev_t usb_ev,
  input  wire udisc_pkg::udisc_txn_t    txn,
  // Pins
  input  wire logic                 wakeup,
  output logic                      irq_out,
  output logic                      suspend_out,
  output logic                      divided_clock_out,
  output logic                      osc_stopped
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic in_bank(input logic [7:0] a,
                                   input logic [7:0] base);
    return a[7:6] == base[7:6];
  endfunction

  // ----------------------------------------------------------------------
  // Bus slave: one wait state, effects at the accept edge
  // ----------------------------------------------------------------------
  logic        bus_done;
  logic        rd_ack;
  logic        wr_ack;
  logic [3:0]  ep_idx;
  logic [23:0] ev;
  logic [23:0] irq_en;
  logic [1:0]  mode;
  logic [7:0]  hwcfg;
  logic [7:0]  ep_cfg [16];
  logic [31:0] next_rdata;

  assign avs_waitrequest = (avs_read | avs_write) & ~bus_done;
  assign rd_ack = avs_read & bus_done;
  assign wr_ack = avs_write & bus_done;
  assign ep_idx = avs_address[5:2];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bus_done <= 1'b0;
    end else begin
      bus_done <= (avs_read | avs_write) & ~bus_done;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (avs_address == udisc_pkg::OFS_EVENT) begin
      next_rdata[23:0] = ev;
      next_rdata[udisc_pkg::EV_BUS_STATE] = usb_ev.bus_suspended;
    end else if (avs_address == udisc_pkg::OFS_IRQ_EN) begin
      next_rdata[23:0] = irq_en;
    end else if (avs_address == udisc_pkg::OFS_MODE) begin
      next_rdata[1:0] = mode;
    end else if (avs_address == udisc_pkg::OFS_HWCFG) begin
      next_rdata[7:0] = hwcfg;
    end else if (in_bank(avs_address, udisc_pkg::OFS_EP_STATUS)) begin
      next_rdata[0]    = ev[udisc_pkg::EV_EP_LO + 32'(ep_idx)];
      next_rdata[15:8] = ep_cfg[ep_idx];
    end else if (in_bank(avs_address, udisc_pkg::OFS_EP_CONFIG)) begin
      next_rdata[7:0] = ep_cfg[ep_idx];
    end
  end

  // Data loaded one cycle early so it stands at the accept edge
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~bus_done) begin
      avs_readdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic [31:0] wr_word;
  assign wr_word = avs_writedata;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_en <= udisc_pkg::IRQ_EN_RST;
      mode   <= udisc_pkg::MODE_RST;
      hwcfg  <= udisc_pkg::HWCFG_RST;
    end else if (wr_ack) begin
      if (avs_address == udisc_pkg::OFS_IRQ_EN) begin
        irq_en <= 24'(be_merge({8'h00, irq_en}, wr_word, avs_byteenable));
      end
      if (avs_address == udisc_pkg::OFS_MODE) begin
        mode <= 2'(be_merge({30'h0, mode}, wr_word, avs_byteenable));
      end
      if (avs_address == udisc_pkg::OFS_HWCFG) begin
        hwcfg <= 8'(be_merge({24'h0, hwcfg}, wr_word, avs_byteenable));
      end
    end
  end

  // Control pair keeps its enable bit whatever is written
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        ep_cfg[i] <= (i < 2) ? udisc_pkg::EPC_CTRL : udisc_pkg::EPC_RST;
      end
    end else if (wr_ack && in_bank(avs_address, udisc_pkg::OFS_EP_CONFIG)
                 && avs_byteenable[0]) begin
      ep_cfg[ep_idx] <= avs_writedata[7:0]
                        | ((ep_idx < 4'h2) ? udisc_pkg::EPC_CTRL : 8'h00);
    end
  end

  // ----------------------------------------------------------------------
  // Event register
  // ----------------------------------------------------------------------
  logic        bus_susp_d;
  logic        pseudo_frame_flag_tick;
  logic [23:0] ev_set;
  logic [23:0] ev_clr;
  logic        txn_hit;

  // NO_ACK never interrupts: OUT data counts only once acknowledged
  assign txn_hit = txn.valid && txn.kind != udisc_pkg::TK_NO_ACK
                   && ep_cfg[txn.ep][udisc_pkg::EPC_ENABLE];

  always_comb begin
    ev_set = 24'h000000;
    ev_set[udisc_pkg::EV_BUS_RESET] = usb_ev.bus_reset;
    ev_set[udisc_pkg::EV_RESUME]    = usb_ev.resume;
    ev_set[udisc_pkg::EV_SUSP_CHG]  = usb_ev.bus_suspended & ~bus_susp_d;
    ev_set[udisc_pkg::EV_EOT]       = usb_ev.dma_count_zero;
    ev_set[udisc_pkg::EV_SOF]       = usb_ev.sof;
    ev_set[udisc_pkg::EV_PSEUDO_FRAME_FLAG]      = pseudo_frame_flag_tick;
    if (txn_hit) begin
      ev_set[udisc_pkg::EV_EP_LO + 32'(txn.ep)] = 1'b1;
    end
    ev_clr = 24'h000000;
    if (rd_ack && avs_address == udisc_pkg::OFS_EVENT) begin
      ev_clr = udisc_pkg::EV_RD_CLR;
    end
    if (wr_ack && avs_address == udisc_pkg::OFS_EVENT && avs_byteenable[0]) begin
      ev_clr = ev_clr | (udisc_pkg::EV_W1C & {16'h0000, avs_writedata[7:0]});
    end
    if (rd_ack && in_bank(avs_address, udisc_pkg::OFS_EP_STATUS)) begin
      ev_clr[udisc_pkg::EV_EP_LO + 32'(ep_idx)] = 1'b1;
    end
  end

  // Set wins over clear so an event set in the accept cycle of a read is not lost
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ev         <= 24'h000000;
      bus_susp_d <= 1'b0;
    end else begin
      ev         <= ((ev & ~ev_clr) | ev_set) & udisc_pkg::EV_LATCHED;
      bus_susp_d <= usb_ev.bus_suspended;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------------
  logic       pending;
  logic       pending_d;
  logic       irq_active;
  logic [2:0] pulse_cnt;
  logic       pulse_on;

  assign pending = |(ev & irq_en);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pending_d <= 1'b0;
      pulse_cnt <= 3'h0;
    end else begin
      pending_d <= pending;
      if (pending & ~pending_d) begin
        pulse_cnt <= 3'(udisc_pkg::PULSE_CYC);
      end else if (pulse_cnt != 3'h0) begin
        pulse_cnt <= pulse_cnt - 3'h1;
      end
    end
  end

  assign pulse_on = pulse_cnt != 3'h0;

  always_comb begin
    if (hwcfg[udisc_pkg::CFG_PULSE]) begin
      irq_active = pulse_on;
    end else begin
      irq_active = pending;
    end
    irq_active = irq_active & mode[udisc_pkg::MODE_GLOBAL];
  end

  // Polarity bit low means active low, as after reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_out <= 1'b1;
    end else begin
      irq_out <= irq_active ~^ hwcfg[udisc_pkg::CFG_POL];
    end
  end

  // ----------------------------------------------------------------------
  // Frame watchdog
  // ----------------------------------------------------------------------
  udisc_pkg::udisc_susp_t sp_state;
  logic [15:0] frame_cnt;
  logic [1:0]  missed;

  assign pseudo_frame_flag_tick = sp_state == udisc_pkg::SP_AWAKE && !usb_ev.sof
                     && frame_cnt == 16'(PSEUDO_FRAME_FLAG_CYC - 1);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      frame_cnt <= 16'h0000;
      missed    <= 2'h0;
    end else if (usb_ev.sof || sp_state != udisc_pkg::SP_AWAKE) begin
      frame_cnt <= 16'h0000;
      missed    <= 2'h0;
    end else if (pseudo_frame_flag_tick) begin
      frame_cnt <= 16'h0000;
      missed    <= (missed == udisc_pkg::MISSED_LIMIT) ? missed : missed + 2'h1;
    end else begin
      frame_cnt <= frame_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Suspend sequencing
  // ----------------------------------------------------------------------
  logic        go_suspend_bit_d;
  logic        wake_s1;
  logic        wake_s2;
  logic        wake_d;
  logic        wake_rise;
  logic [15:0] sp_cnt;
  logic        go_sleep;

  // Wake-up pin is asynchronous, so synchronise before edge detection
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wake_s1  <= 1'b0;
      wake_s2  <= 1'b0;
      wake_d   <= 1'b0;
      go_suspend_bit_d <= 1'b0;
    end else begin
      wake_s1  <= wakeup;
      wake_s2  <= wake_s1;
      wake_d   <= wake_s2;
      go_suspend_bit_d <= mode[udisc_pkg::MODE_GO_SUSPEND_BIT];
    end
  end

  assign wake_rise = wake_s2 & ~wake_d;
  assign go_sleep  = (go_suspend_bit_d & ~mode[udisc_pkg::MODE_GO_SUSPEND_BIT])
                     | (missed == udisc_pkg::MISSED_LIMIT);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sp_state <= udisc_pkg::SP_AWAKE;
      sp_cnt   <= 16'h0000;
    end else begin
      unique case (sp_state)
        udisc_pkg::SP_AWAKE: begin
          sp_cnt <= 16'h0000;
          if (go_sleep) begin
            sp_state <= udisc_pkg::SP_ENTER;
          end
        end
        udisc_pkg::SP_ENTER: begin
          if (sp_cnt == 16'(SUSP_CYC - 1)) begin
            sp_state <= udisc_pkg::SP_ASLEEP;
            sp_cnt   <= 16'h0000;
          end else begin
            sp_cnt <= sp_cnt + 16'h0001;
          end
        end
        udisc_pkg::SP_ASLEEP: begin
          if (wake_rise) begin
            sp_state <= udisc_pkg::SP_RESUME;
          end
        end
        udisc_pkg::SP_RESUME: begin
          if (sp_cnt == 16'(RESUME_CYC - 1)) begin
            sp_state <= udisc_pkg::SP_AWAKE;
          end else begin
            sp_cnt <= sp_cnt + 16'h0001;
          end
        end
      endcase
    end
  end

  // Resume delay lets the oscillator settle before the clock returns
  assign suspend_out = sp_state == udisc_pkg::SP_ASLEEP;
  assign osc_stopped = suspend_out | sp_state == udisc_pkg::SP_RESUME
                       | ~hwcfg[udisc_pkg::CFG_OSC_RUN];

  // ----------------------------------------------------------------------
  // Clock output divider
  // ----------------------------------------------------------------------
  logic [7:0] clk_half;
  logic [7:0] clk_cnt;
  logic       clk_run;
  logic       slow_run;
  logic       sleep_next;

  // Entry edge, so a stopped clock leaves no stray high cycle in suspend
  assign sleep_next = sp_state == udisc_pkg::SP_ENTER
                      && sp_cnt == 16'(SUSP_CYC - 1);

  assign slow_run = suspend_out & ~hwcfg[udisc_pkg::CFG_SLOW_DIS];
  assign clk_run  = ~osc_stopped | slow_run;
  assign clk_half = slow_run ? 8'(udisc_pkg::SLOW_HALF_CYC)
                    : {4'h0, hwcfg[udisc_pkg::CFG_DIV_LO +: 4]} + 8'h01;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clk_cnt           <= 8'h00;
      divided_clock_out <= 1'b0;
    end else if (!clk_run
                 || (sleep_next && hwcfg[udisc_pkg::CFG_SLOW_DIS])) begin
      clk_cnt           <= 8'h00;
      divided_clock_out <= 1'b0;
    end else if (clk_cnt >= clk_half - 8'h01) begin
      clk_cnt           <= 8'h00;
      divided_clock_out <= ~divided_clock_out;
    end else begin
      clk_cnt <= clk_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_global_mask;
    @(posedge clk_sys) disable iff (reset)
    !mode[udisc_pkg::MODE_GLOBAL]
    |=> irq_out != $past(hwcfg[udisc_pkg::CFG_POL]);
  endproperty
  a_global_mask: assert property (p_global_mask)
    else $error("interrupt asserted while globally masked");

  property p_level_hold;
    @(posedge clk_sys) disable iff (reset)
    mode[udisc_pkg::MODE_GLOBAL] && !hwcfg[udisc_pkg::CFG_PULSE] && pending
    |=> irq_out == $past(hwcfg[udisc_pkg::CFG_POL]);
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("level interrupt not asserted with pending event");

  property p_pulse_width;
    @(posedge clk_sys) disable iff (reset)
    pending && !pending_d |=> pulse_on [*5] ##1 !pulse_on || pending_d;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("interrupt pulse length wrong");

  property p_read_clear;
    @(posedge clk_sys) disable iff (reset)
    rd_ack && avs_address == udisc_pkg::OFS_EVENT && !usb_ev.bus_reset
    |=> !ev[udisc_pkg::EV_BUS_RESET];
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("bus reset bit survived event read");

  property p_ep_sticky;
    @(posedge clk_sys) disable iff (reset)
    |($past(ev[23:udisc_pkg::EV_EP_LO]) & ~ev[23:udisc_pkg::EV_EP_LO])
    |-> $past(rd_ack)
      && $past(in_bank(avs_address, udisc_pkg::OFS_EP_STATUS));
  endproperty
  a_ep_sticky: assert property (p_ep_sticky)
    else $error("endpoint bit cleared without status read");

  property p_pseudo_frame_flag_set;
    @(posedge clk_sys) disable iff (reset)
    pseudo_frame_flag_tick |=> ev[udisc_pkg::EV_PSEUDO_FRAME_FLAG];
  endproperty
  a_pseudo_frame_flag_set: assert property (p_pseudo_frame_flag_set)
    else $error("pseudo frame event not logged");

  property p_auto_susp;
    @(posedge clk_sys) disable iff (reset)
    sp_state == udisc_pkg::SP_AWAKE && missed == udisc_pkg::MISSED_LIMIT
    |=> sp_state == udisc_pkg::SP_ENTER;
  endproperty
  a_auto_susp: assert property (p_auto_susp)
    else $error("no suspend after missed frames");

  property p_susp_delay;
    @(posedge clk_sys) disable iff (reset)
    $rose(suspend_out) |-> $past(sp_cnt) == 16'(SUSP_CYC - 1);
  endproperty
  a_susp_delay: assert property (p_susp_delay)
    else $error("suspend output changed before delay elapsed");

  property p_wake;
    @(posedge clk_sys) disable iff (reset)
    suspend_out && wake_rise |=> !suspend_out ##1 osc_stopped;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake-up did not clear suspend");

  property p_osc_off;
    @(posedge clk_sys) disable iff (reset)
    suspend_out |-> osc_stopped && (slow_run || !divided_clock_out);
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator running in suspend");

endmodule

// ==== verif/udisc_host.sv ====
// Host interrupt input model: width of each irq assertion
`timescale 1ns/1ns
module udisc_host (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Interrupt pin and the polarity firmware chose
  input  wire logic       irq_out,
  input  wire logic       pol_high,
  // Length of the last assertion in cycles
  output logic      [7:0] width
);
  logic [7:0] run;
  // --------------------------------------------
  // Assertion width
  // --------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      run   <= 8'h00;
      width <= 8'h00;
    end else if (irq_out == pol_high) begin
      run <= run + 8'h01;
    end else begin
      if (run != 8'h00) begin
        width <= run;
      end
      run <= 8'h00;
    end
  end
endmodule

// ==== verif/udisc_core_test.sv ====
// Self-checking bench of the USB interrupt and suspend clock block
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module udisc_core_test;
  logic                     clk_sys = 1'h0;
  logic                     reset = 1'h1;
  logic [7:0]               avs_address = 8'h00;
  logic                     avs_read = 1'h0, avs_write = 1'h0;
  logic [31:0]              avs_writedata = 32'h0, avs_readdata;
  logic                     avs_waitrequest, irq_out, suspend_out;
  logic                     divided_clock_out, osc_stopped;
  logic                     br = 1'h0, rs = 1'h0, dz = 1'h0, bsus = 1'h0;
  logic                     sofp = 1'h0, sof_on = 1'h0;
  logic                     wakeup = 1'h0, pol = 1'h0;
  logic [4:0]               sof_cnt = 5'h00;
  logic [7:0]               width;
  logic [31:0]              seed = 32'h96381773, got, ex;
  logic [31:0]              ev_q[$], em_q[$];
  udisc_pkg::udisc_usb_ev_t usb_ev;
  udisc_pkg::udisc_txn_t    txn = '0;
  int                       checked = 0, mismatches = 0, n, k, e;
  // --------------------------------------------
  // Harness
  // --------------------------------------------
  assign usb_ev = {br, rs, sofp, dz, bsus};
  always #20 clk_sys = ~clk_sys;
  udisc_core #(.PSEUDO_FRAME_FLAG_CYC(50), .SUSP_CYC(40), .RESUME_CYC(20)) udisc_core_i (
    .clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .usb_ev, .txn,
    .wakeup, .irq_out, .suspend_out, .divided_clock_out, .osc_stopped);
  udisc_host udisc_host_i (.clk_sys, .reset, .irq_out, .pol_high(pol), .width);
  // Frame starts well inside the watchdog span while enabled
  always @(posedge clk_sys) begin
    sof_cnt <= sof_cnt + 5'h01;
    sofp    <= sof_on && (sof_cnt == 5'h1F);
  end
  always @(posedge clk_sys) begin
    if (avs_read === 1'h1 && avs_waitrequest === 1'h0) begin
      got = avs_readdata & em_q.pop_front();
      ex  = ev_q.pop_front();
      `CHK(got, ex);
    end
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'h0);
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [31:0] m);
    ev_q.push_back(v & m);
    em_q.push_back(m);
    bus(1'h0, a, 32'h0);
  endtask
  // Second of two intervals, so a divider change mid-period is skipped
  task automatic gap(output int h);
    logic v;
    repeat (2) begin
      v = divided_clock_out;
      h = 0;
      while (divided_clock_out === v && h < 600) begin
        cyc(1);
        h++;
      end
    end
  endtask
  task automatic wait_susp();
    n = 0;
    while (suspend_out !== 1'h1 && n < 400) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic wake();
    @(posedge clk_sys);
    wakeup <= 1'h1;
    cyc(2);
    wakeup <= 1'h0;
    n = 0;
    while (suspend_out !== 1'h0 && n < 10) begin
      cyc(1);
      n++;
    end
    `CHK(suspend_out, 1'h0);
  endtask
  task automatic wrap_up();
    $display("counts: checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // --------------------------------------------
  // Tests
  // --------------------------------------------
  initial begin
    cyc(20000);
    mismatches++;
    wrap_up();
  end
  initial begin
    cyc(16);
    reset  <= 1'h0;
    sof_on <= 1'h1;
    cyc(1);
    `CHK(irq_out, 1'h1);
    rd(8'h0C, 32'h0, 32'h03);
    rd(8'h80, 32'h1, 32'hFF);
    rd(8'h8C, 32'h0, 32'hFF);
    rd(8'h30, 32'h0, 32'hFFFFFFFF);
    $display("done: reset");
    wr(8'h04, 32'h3);
    @(posedge clk_sys);
    br <= 1'h1;
    rs <= 1'h1;
    @(posedge clk_sys);
    br <= 1'h0;
    rs <= 1'h0;
    cyc(3);
    `CHK(irq_out, 1'h1);
    wr(8'h08, 32'h1);
    cyc(2);
    `CHK(irq_out, 1'h0);
    rd(8'h00, 32'h3, 32'hFFFFFFCF);
    rd(8'h00, 32'h0, 32'hFFFFFFCF);
    cyc(2);
    `CHK(irq_out, 1'h1);
    wr(8'h0C, 32'h07);
    pol <= 1'h1;
    wr(8'h04, 32'h08);
    @(posedge clk_sys);
    dz <= 1'h1;
    @(posedge clk_sys);
    dz <= 1'h0;
    cyc(12);
    `CHK(width, 8'(udisc_pkg::PULSE_CYC));
    rd(8'h00, 32'h08, 32'h08);
    $display("done: irq");
    for (k = 0; k < 3; k++) begin
      e = rnd() % 16;
      wr(8'h0C, {24'h0, e[3:0], 4'h4});
      gap(n);
      `CHK(n, e + 1);
    end
    wr(8'h0C, 32'h0);
    cyc(2);
    `CHK(osc_stopped, 1'h1);
    wr(8'h0C, 32'h04);
    $display("done: clock");
    for (k = 2; k < 16; k++) begin
      wr(8'h80 + 8'(k * 4), 32'h1);
    end
    for (k = 0; k < 8; k++) begin
      e = rnd() % 16;
      n = (k % 4 != 3);
      @(posedge clk_sys);
      txn <= {1'h1, 2'(k % 4), 4'(e)};
      @(posedge clk_sys);
      txn <= '0;
      rd(8'h00, 32'(n) << (8 + e), 32'h1 << (8 + e));
      rd(8'h00, 32'(n) << (8 + e), 32'h1 << (8 + e));
      rd(8'h40 + 8'(e * 4), 32'h100 | n, 32'hFF01);
      rd(8'h00, 32'h0, 32'h1 << (8 + e));
    end
    $display("done: endpoints");
    sof_on <= 1'h0;
    rd(8'h00, 32'h0, 32'hFFFF00);
    wr(8'h04, 32'h30);
    cyc(60);
    `CHK(irq_out, 1'h0);
    rd(8'h00, 32'h20, 32'h20);
    wait_susp();
    `CHK(suspend_out, 1'h1);
    `CHK(osc_stopped, 1'h1);
    gap(n);
    `CHK(n, int'(udisc_pkg::SLOW_HALF_CYC));
    bsus <= 1'h1;
    rd(8'h00, 32'h84, 32'h84);
    wake();
    bsus   <= 1'h0;
    sof_on <= 1'h1;
    cyc(10);
    `CHK(divided_clock_out, 1'h0);
    cyc(1);
    `CHK(divided_clock_out, 1'h0);
    gap(n);
    `CHK(n, 1);
    rd(8'h00, 32'h0, 32'h80);
    wr(8'h0C, 32'h0C);
    wr(8'h08, 32'h3);
    wr(8'h08, 32'h1);
    wait_susp();
    `CHK(n > 30 && n < 50, 1'h1);
    cyc(3);
    `CHK(divided_clock_out, 1'h0);
    cyc(130);
    `CHK(divided_clock_out, 1'h0);
    wake();
    rd(8'h00, 32'h24, 32'h24);
    wr(8'h00, 32'h24);
    rd(8'h00, 32'h0, 32'h24);
    $display("done: suspend");
    wrap_up();
  end
endmodule
